// File: include/modem_spi_pkg.sv
package modem_spi_pkg;

    // Frame layout
    localparam int FRAME_BITS  = 24;
    localparam int CRC_BITS    = 8;
    localparam int WORD_BITS   = 32;
    localparam int RW_BIT      = 23;
    localparam int ADDR_HI     = 22;
    localparam int ADDR_LO     = 16;
    localparam int DATA_HI     = 15;
    localparam int IDX_BITS    = 6;

    // Register addresses
    localparam logic [6:0] ADDR_HOST_CFG  = 7'h02;
    localparam logic [6:0] ADDR_SOFT_RST  = 7'h07;
    localparam logic [6:0] ADDR_EVT_FLAGS = 7'h20;
    localparam logic [6:0] ADDR_EVT_MASK  = 7'h21;
    localparam logic [6:0] ADDR_LINK_CFG  = 7'h22;
    localparam logic [6:0] ADDR_TX_QUEUE  = 7'h23;
    localparam logic [6:0] ADDR_RX_QUEUE  = 7'h24;
    localparam logic [6:0] ADDR_QUEUE_THR = 7'h25;
    localparam logic [6:0] ADDR_TALK_LIM  = 7'h27;

    // Reset values and write masks
    localparam logic [15:0] HOST_CFG_RST   = 16'h8042;
    localparam logic [15:0] HOST_CFG_WMASK = 16'hf05f;
    localparam logic [15:0] EVT_MASK_RST   = 16'hffff;
    localparam logic [15:0] PLAIN_RST      = 16'h0000;
    localparam logic [15:0] SOFT_RST_KEY   = 16'h0001;

    // Host configuration fields
    localparam int CFG_IRQ_EDGE_BIT = 2;
    localparam int CFG_INTERRUPT_POLARITY_BIT_BIT  = 3;
    localparam int CFG_CRC_EN_BIT   = 4;
    localparam int CFG_REF_BIT      = 6;
    localparam int CFG_WD_EN_BIT    = 12;
    localparam int CFG_WD_SEL_HI    = 15;
    localparam int CFG_WD_SEL_LO    = 13;

    // Event flags
    localparam logic [15:0] EVT_WATCHDOG_MASK = 16'h0200;

    // Checksum
    localparam logic [7:0]  CRC_POLY     = 8'h07;
    localparam logic [7:0]  CRC_INIT     = 8'h00;
    localparam logic [31:0] BAD_CRC_WORD = 32'h80000000;

    // Watchdog periods in milliseconds, indexed by the period select field
    localparam int WD_PERIOD_MS [8] = '{50, 100, 500, 1000, 2000, 3000, 4000, 5000};
    localparam int CLK_HZ           = 50_000_000;
    localparam int MS_PER_S         = 1000;

endpackage

// File: include/crc_if.sv
interface crc_if;
    import modem_spi_pkg::*;

    logic [FRAME_BITS-1:0] data;
    logic [CRC_BITS-1:0]   crc;

    modport calc (input data, output crc);
    modport user (output data, input crc);
endinterface

// File: rtl/frame_crc8.sv
module frame_crc8
(
    // Word in, checksum out
    crc_if.calc port
);
    import modem_spi_pkg::*;

    logic [CRC_BITS-1:0] acc;
    logic                fb;

    // MSB first, zero seed, generator x^8+x^2+x+1
    always_comb
    begin
        acc = CRC_INIT;
        fb  = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--)
        begin
            fb  = acc[CRC_BITS-1] ^ port.data[i];
            acc = {acc[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
        end
    end

    assign port.crc = acc;
endmodule

// File: rtl/modem_spi_host_port.sv
//Operation
// - On chip select rise only the last 24 or 32 bits count.
// - Clock idle low sample second edge, or idle high sample first edge.
// - Serial output changes on rising clock; first bit on chip select fall.
// - Output returns prior frame: read data, or echoed write word.
// - Echoed write returns the received checksum byte, not a new one.
// - Bit 23 direction (1 read), bits 22:16 address, 15:0 data.
// - With checking on, last byte is CRC x^8+x^2+x+1 both ways.
// - Checking is enabled by one bit of host configuration.
// - Write with bad checksum changes no register; the next frame returns 0x80000000.
// - Bad-checksum read returns 0x80000000 and does not pop receive queue.
// - Config bit 2 picks level or edge, bit 3 picks interrupt polarity.
// - Mask bit 0 passes the event to interrupt, 1 blocks it.
// - Level mode: interrupt latched until event flags register is read.
// - Edge mode: one pulse per new unmasked event.
// - Bit 12 enables watchdog, bits 15:13 select its timeout.
// - Host configuration resets to 0x8042.
// - Writing 0x0001 to soft reset restores defaults and empties queues.
module modem_spi_host_port
#(
    parameter int WD_TICKS_PER_MS = modem_spi_pkg::CLK_HZ / modem_spi_pkg::MS_PER_S
)
(
    // System
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // Serial link
    input  wire logic         sclk_in,
    input  wire logic         cs_n_in,
    input  wire logic         sdi_in,
    output logic              sdo_out,
    output logic              sdo_oe_out,
    // Interrupt
    output logic              irq_out,
    // Modem side
    input  wire logic [15:0]  event_in,
    input  wire logic [15:0]  rx_q_data_in,
    output logic              tx_q_wr_out,
    output logic [15:0]       tx_q_data_out,
    output logic              rx_q_rd_out,
    output logic              queue_flush_out,
    output logic [15:0]       link_cfg_out,
    output logic [15:0]       queue_thr_out,
    output logic [15:0]       talk_limit_out,
    output logic              internal_reference_power_out
);
    import modem_spi_pkg::*;

    // Link clock domain
    logic [WORD_BITS-1:0]  rx_shift_reg;
    logic [IDX_BITS-1:0]   fall_cnt_reg;
    logic [IDX_BITS-1:0]   tx_idx_reg;
    logic [IDX_BITS-1:0]   tx_base;
    logic                  tx_in_range;

    // System clock domain
    logic [2:0]            cs_sync_reg;
    logic                  cs_level_reg;
    logic                  cs_agree;
    logic                  frame_end;
    logic [15:0]           host_cfg_reg;
    logic [15:0]           host_cfg_next;
    logic [15:0]           evt_mask_reg;
    logic [15:0]           link_cfg_reg;
    logic [15:0]           queue_thr_reg;
    logic [15:0]           talk_limit_reg;
    logic [15:0]           evt_flags_reg;
    logic [15:0]           evt_flags_next;
    logic [15:0]           evt_raise;
    logic [15:0]           flag_clr;
    logic [31:0]           wd_cnt_reg;
    logic [31:0]           wd_limit;
    logic                  irq_latch_reg;
    logic                  irq_latch_next;
    logic                  irq_pulse_reg;
    logic                  irq_active;
    logic [WORD_BITS-1:0]  resp_reg;
    logic [WORD_BITS-1:0]  resp_next;
    logic                  resp_long_reg;
    logic                  tx_q_wr_reg;
    logic [15:0]           tx_q_data_reg;
    logic                  rx_q_rd_reg;
    logic                  flush_reg;

    // Decode
    logic                  crc_en;
    logic                  edge_mode;
    logic                  wd_en;
    logic [2:0]            wd_sel;
    logic [FRAME_BITS-1:0] frame_word;
    logic [CRC_BITS-1:0]   rx_crc;
    logic                  crc_ok;
    logic                  is_read;
    logic [6:0]            addr;
    logic [15:0]           wdata;
    logic [15:0]           rd_data;
    logic [FRAME_BITS-1:0] read_word;
    logic                  good_wr;
    logic                  good_rd;
    logic                  bad_frame;
    logic                  wr_host_cfg;
    logic                  wr_flags;
    logic                  soft_rst;
    logic                  rst_all;
    logic                  flags_read;
    logic                  new_unmasked;
    logic                  wd_timeout;
    logic                  frame_valid;

    crc_if rx_chk ();
    crc_if tx_gen ();

    frame_crc8 u_rx_crc
    (
        .port (rx_chk.calc)
    );

    frame_crc8 u_tx_crc
    (
        .port (tx_gen.calc)
    );

    // Sample on the falling edge in both supported modes
    always_ff @(negedge sclk_in)
    begin
        if (!cs_n_in)
            rx_shift_reg <= {rx_shift_reg[WORD_BITS-2:0], sdi_in};
    end

    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            fall_cnt_reg <= '0;
        else if (fall_cnt_reg != '1)
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end

    // Output index follows the sampled count, so idle-low framing keeps bit 0
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            tx_idx_reg <= '0;
        else
            tx_idx_reg <= fall_cnt_reg;
    end

    // Response word is stable while a frame is open
    assign tx_base     = resp_long_reg ? IDX_BITS'(WORD_BITS - 1) : IDX_BITS'(FRAME_BITS - 1);
    assign tx_in_range = tx_idx_reg <= tx_base;
    assign sdo_out     = tx_in_range ? resp_reg[5'(tx_base - tx_idx_reg)] : 1'b0;
    assign sdo_oe_out  = !cs_n_in;

    // Chip select synchroniser
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            cs_sync_reg <= 3'h7;
        else
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n_in};
    end

    assign cs_agree  = cs_sync_reg[1] == cs_sync_reg[2];
    assign frame_end = cs_agree && cs_sync_reg[2] && !cs_level_reg;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            cs_level_reg <= 1'b1;
        else if (cs_agree)
            cs_level_reg <= cs_sync_reg[2];
    end

    // Configuration fields
    assign crc_en    = host_cfg_reg[CFG_CRC_EN_BIT];
    assign edge_mode = host_cfg_reg[CFG_IRQ_EDGE_BIT];
    assign wd_en     = host_cfg_reg[CFG_WD_EN_BIT];
    assign wd_sel    = host_cfg_reg[CFG_WD_SEL_HI:CFG_WD_SEL_LO];

    // Frame decode; the word is right justified in the shift register
    assign frame_word = crc_en ? rx_shift_reg[WORD_BITS-1:CRC_BITS]
                               : rx_shift_reg[FRAME_BITS-1:0];
    assign rx_crc     = rx_shift_reg[CRC_BITS-1:0];
    assign rx_chk.data = frame_word;
    assign crc_ok     = !crc_en || (rx_chk.crc == rx_crc);
    assign is_read    = frame_word[RW_BIT];
    assign addr       = frame_word[ADDR_HI:ADDR_LO];
    assign wdata      = frame_word[DATA_HI:0];
    assign good_wr    = frame_end && !is_read && crc_ok;
    assign good_rd    = frame_end && is_read && crc_ok;
    assign bad_frame  = frame_end && !crc_ok;
    assign frame_valid = good_wr || good_rd;

    assign wr_host_cfg = good_wr && (addr == ADDR_HOST_CFG);
    assign wr_flags    = good_wr && (addr == ADDR_EVT_FLAGS);
    assign soft_rst    = good_wr && (addr == ADDR_SOFT_RST) && (wdata == SOFT_RST_KEY);
    assign rst_all     = srst_in || soft_rst;
    assign flags_read  = good_rd && (addr == ADDR_EVT_FLAGS);

    // Register read selection
    assign rd_data =
        (addr == ADDR_HOST_CFG)  ? (host_cfg_reg & HOST_CFG_WMASK) :
        (addr == ADDR_EVT_FLAGS) ? evt_flags_reg :
        (addr == ADDR_EVT_MASK)  ? evt_mask_reg :
        (addr == ADDR_LINK_CFG)  ? link_cfg_reg :
        (addr == ADDR_RX_QUEUE)  ? rx_q_data_in :
        (addr == ADDR_QUEUE_THR) ? queue_thr_reg :
        (addr == ADDR_TALK_LIM)  ? talk_limit_reg : PLAIN_RST;

    // Response for the next frame
    assign read_word   = {1'b1, addr, rd_data};
    assign tx_gen.data = read_word;
    assign resp_next =
        bad_frame ? BAD_CRC_WORD :
        !good_rd  ? rx_shift_reg :
        crc_en    ? {read_word, tx_gen.crc} :
                    {{CRC_BITS{1'b0}}, read_word};

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            resp_reg      <= '0;
            resp_long_reg <= 1'b0;
        end
        else if (frame_end)
        begin
            resp_reg      <= resp_next;
            resp_long_reg <= crc_en;
        end
    end

    // Host configuration
    assign host_cfg_next = wr_host_cfg ? (wdata & HOST_CFG_WMASK) : host_cfg_reg;

    always_ff @(posedge clk_in)
    begin
        if (rst_all)
            host_cfg_reg <= HOST_CFG_RST;
        else
            host_cfg_reg <= host_cfg_next;
    end

    // Plain read/write registers
    always_ff @(posedge clk_in)
    begin
        if (rst_all)
        begin
            evt_mask_reg   <= EVT_MASK_RST;
            link_cfg_reg   <= PLAIN_RST;
            queue_thr_reg  <= PLAIN_RST;
            talk_limit_reg <= PLAIN_RST;
        end
        else if (good_wr)
        begin
            if (addr == ADDR_EVT_MASK)
                evt_mask_reg <= wdata;
            if (addr == ADDR_LINK_CFG)
                link_cfg_reg <= wdata;
            if (addr == ADDR_QUEUE_THR)
                queue_thr_reg <= wdata;
            if (addr == ADDR_TALK_LIM)
                talk_limit_reg <= wdata;
        end
    end

    // Queue strobes; a bad read never pops
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            tx_q_wr_reg   <= 1'b0;
            tx_q_data_reg <= PLAIN_RST;
            rx_q_rd_reg   <= 1'b0;
            flush_reg     <= 1'b0;
        end
        else
        begin
            tx_q_wr_reg   <= good_wr && (addr == ADDR_TX_QUEUE);
            tx_q_data_reg <= good_wr ? wdata : tx_q_data_reg;
            rx_q_rd_reg   <= good_rd && (addr == ADDR_RX_QUEUE);
            flush_reg     <= soft_rst;
        end
    end

    // Watchdog, restarted by every valid frame
    assign wd_limit   = 32'(WD_PERIOD_MS[wd_sel] * WD_TICKS_PER_MS);
    assign wd_timeout = wd_en && (wd_cnt_reg >= wd_limit - 32'h1);

    always_ff @(posedge clk_in)
    begin
        if (rst_all || !wd_en || frame_valid || wd_timeout)
            wd_cnt_reg <= '0;
        else
            wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end

    // Sticky event flags, write one to clear, a new event beats the clear
    assign evt_raise      = event_in | (wd_timeout ? EVT_WATCHDOG_MASK : PLAIN_RST);
    assign flag_clr       = wr_flags ? wdata : PLAIN_RST;
    assign evt_flags_next = (evt_flags_reg & ~flag_clr) | evt_raise;
    assign new_unmasked   = |(evt_raise & ~evt_mask_reg);

    always_ff @(posedge clk_in)
    begin
        if (rst_all)
            evt_flags_reg <= PLAIN_RST;
        else
            evt_flags_reg <= evt_flags_next;
    end

    // Interrupt latch and pulse
    assign irq_latch_next = new_unmasked || (irq_latch_reg && !flags_read);

    always_ff @(posedge clk_in)
    begin
        if (rst_all)
        begin
            irq_latch_reg <= 1'b0;
            irq_pulse_reg <= 1'b0;
        end
        else
        begin
            irq_latch_reg <= irq_latch_next;
            irq_pulse_reg <= new_unmasked;
        end
    end

    assign irq_active = edge_mode ? irq_pulse_reg : irq_latch_reg;
    assign irq_out    = host_cfg_reg[CFG_INTERRUPT_POLARITY_BIT_BIT] ? irq_active : !irq_active;

    // Outputs
    assign tx_q_wr_out     = tx_q_wr_reg;
    assign tx_q_data_out   = tx_q_data_reg;
    assign rx_q_rd_out     = rx_q_rd_reg;
    assign queue_flush_out = flush_reg;
    assign link_cfg_out    = link_cfg_reg;
    assign queue_thr_out   = queue_thr_reg;
    assign talk_limit_out  = talk_limit_reg;
    assign internal_reference_power_out = host_cfg_reg[CFG_REF_BIT];

    // Checks
    sequence bad_read_seen;
        bad_frame && is_read;
    endsequence

    sequence bad_write_seen;
        bad_frame && !is_read;
    endsequence

    sequence wd_fire;
        wd_timeout && !soft_rst;
    endsequence

    a_bad_read_word: assert property (@(posedge clk_in) disable iff (srst_in)
        bad_read_seen |=> (resp_reg == BAD_CRC_WORD) && !rx_q_rd_reg)
        else $error("bad checksum read did not return the error word");

    a_bad_write_drop: assert property (@(posedge clk_in) disable iff (srst_in)
        bad_write_seen |=> $stable(host_cfg_reg) && $stable(evt_mask_reg) && !tx_q_wr_reg)
        else $error("bad checksum write changed state");

    a_write_echo_word: assert property (@(posedge clk_in) disable iff (srst_in)
        good_wr |=> (resp_reg == $past(rx_shift_reg)))
        else $error("write frame not echoed with its own checksum");

    a_level_irq_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!edge_mode && irq_latch_reg && !flags_read && !soft_rst) |=> irq_latch_reg [*2]
        or (irq_latch_reg ##1 ($past(flags_read) || $past(soft_rst))))
        else $error("level interrupt released without a flags read");

    a_edge_irq_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
        (edge_mode && !new_unmasked && !soft_rst) |=> !irq_pulse_reg)
        else $error("edge interrupt pulse without a new event");

    a_mask_blocks_irq: assert property (@(posedge clk_in) disable iff (srst_in)
        (!irq_latch_reg && !new_unmasked) |=> !irq_latch_reg)
        else $error("masked event raised the interrupt");

    a_soft_reset_all: assert property (@(posedge clk_in) disable iff (srst_in)
        soft_rst |=> (host_cfg_reg == HOST_CFG_RST) && queue_flush_out
        && (evt_flags_reg == $past(evt_raise) || evt_flags_reg == PLAIN_RST))
        else $error("soft reset did not restore defaults");

    a_cfg_reset_val: assert property (@(posedge clk_in)
        srst_in |=> (host_cfg_reg == HOST_CFG_RST) && (resp_reg == '0))
        else $error("host configuration reset value wrong");

    a_wd_sets_flag: assert property (@(posedge clk_in) disable iff (srst_in)
        wd_fire |=> (|(evt_flags_reg & EVT_WATCHDOG_MASK)) && (wd_cnt_reg == '0))
        else $error("watchdog timeout did not set its flag");

    a_polarity_low: assert property (@(posedge clk_in) disable iff (srst_in)
        (!host_cfg_reg[CFG_INTERRUPT_POLARITY_BIT_BIT] && !edge_mode && irq_latch_reg) |-> !irq_out)
        else $error("active low level interrupt not low");
endmodule

// File: test/spi_host_model.sv
module spi_host_model
(
    // Serial link
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sclk_out = 1'b0; // Clock idle low, stands still between frames
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    // Shifts the low nbits of tx MSB first and captures the reply on each falling edge
    task automatic xfer(input logic [31:0] tx, input int nbits, input bit idle_hi,
                        output logic [31:0] rx);
        rx       = '0;
        sclk_out = idle_hi; // Idle level of the chosen clock arrangement
        #5;
        cs_n_out = 1'b0;
        #5;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sclk_out = 1'b1;
            sdi_out  = tx[i]; // Direction, address, data, checksum in order
            #3;
            sclk_out = 1'b0; // Sampling edge in both clock arrangements
            rx       = {rx[30:0], sdo_in};
            #3;
        end
        sclk_out = idle_hi;
        sdi_out  = ~sdi_out; // Released line never shows the last bit
        #2;
        cs_n_out = 1'b1;
        #3100; // Spacing above the slower frame rate
    endtask
endmodule

// File: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import modem_spi_pkg::*;

    typedef struct packed { logic [23:0] tx; logic [23:0] rx; } row_t;

    logic        clk_in       = 1'b0;
    logic        srst_in      = 1'b1;
    logic [15:0] event_in     = 16'h0000;
    logic [15:0] rx_q_data_in = 16'h3c3c;
    logic        sclk, cs_n, sdi, sdo, irq_out, tx_wr, rx_rd, flush, oe, ref_pwr;
    logic [15:0] tx_data, link_cfg, q_thr, talk_lim, tx_seen;
    logic [31:0] rx;
    int          n_fail       = 0;
    int          cmp_count    = 0;
    int          n_tx = 0, n_rd = 0, n_flush = 0, n_irq = 0;
    bit          idle_hi      = 1'b0;

    // Frame sent beside the reply expected during that frame
    row_t rows [10] = '{
        '{24'h820000, 24'h000000}, '{24'h221234, 24'h828042},
        '{24'ha20000, 24'h221234}, '{24'h2500a5, 24'ha21234},
        '{24'ha50000, 24'h2500a5}, '{24'ha10000, 24'ha500a5},
        '{24'hd0beef, 24'ha1ffff}, '{24'hd00000, 24'hd00000}, // Reserved only read
        '{24'ha30000, 24'hd00000}, '{24'h270bad, 24'ha30000}};

    always #10 clk_in = ~clk_in;

    modem_spi_host_port #(.WD_TICKS_PER_MS(5)) u_dut (
        .clk_in(clk_in), .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe), .irq_out(irq_out),
        .event_in(event_in), .rx_q_data_in(rx_q_data_in), .tx_q_wr_out(tx_wr),
        .tx_q_data_out(tx_data), .rx_q_rd_out(rx_rd), .queue_flush_out(flush),
        .link_cfg_out(link_cfg), .queue_thr_out(q_thr), .talk_limit_out(talk_lim),
        .internal_reference_power_out(ref_pwr));

    spi_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));

    always @(negedge clk_in)
    begin
        n_tx    += (tx_wr === 1'b1);
        n_rd    += (rx_rd === 1'b1);
        n_flush += (flush === 1'b1);
        n_irq   += (irq_out === 1'b1);
        if (tx_wr === 1'b1)
            tx_seen = tx_data;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] crc8(input logic [23:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Sends one frame, with a good or a broken checksum byte when checking is on
    task automatic frame(input logic [23:0] w, input bit crc_on, input bit bad);
        logic [7:0] c;
        c = crc8(w) ^ {7'h00, bad};
        if (crc_on)
            u_host.xfer({w, c}, 32, idle_hi, rx);
        else
            u_host.xfer({8'h00, w}, 24, idle_hi, rx);
    endtask

    task automatic pulse(input logic [15:0] ev);
        @(negedge clk_in) event_in = ev;
        @(negedge clk_in) event_in = 16'h0000;
        repeat (10) @(negedge clk_in);
    endtask

    task automatic wait_irq(input logic lvl);
        int k;
        k = 0;
        while (irq_out !== lvl && k < 100)
        begin
            @(negedge clk_in);
            k++;
        end
        if (k == 100)
        begin
            n_fail++;
            $display("[ERR] irq_out expected %b seen timeout", lvl);
            close_out();
        end
    endtask

    initial
    begin
        repeat (10) @(negedge clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check("link_cfg", 32'(link_cfg), 32'h0);
        check("irq idle", 32'(irq_out), 32'h1);
        check("ref power", 32'(ref_pwr), 32'h1);
        check("sdo enable", 32'(oe), 32'h0);
        foreach (rows[i])
        begin
            frame(rows[i].tx, 0, 0);
            check("row reply", rx, {8'h00, rows[i].rx});
        end
        check("link_cfg", 32'(link_cfg), 32'h1234);
        check("queue_thr", 32'(q_thr), 32'h00a5);
        check("talk_limit", 32'(talk_lim), 32'h0bad);
        $display("register rows done");

        u_host.xfer({4'h0, 4'hf, 24'h271111}, 28, idle_hi, rx);
        check("talk_limit", 32'(talk_lim), 32'h1111);
        frame(24'h235a5a, 0, 0);
        check("tx writes", n_tx, 1);
        check("tx data", 32'(tx_seen), 32'h5a5a);
        frame(24'ha40000, 0, 0);
        check("rx pops", n_rd, 1);
        $display("queue test done");

        frame(24'h21fffe, 0, 0);
        check("rx reply", rx, 32'ha43c3c);
        frame(24'h02804e, 0, 0);
        n_irq = 0;
        pulse(16'h0001);
        pulse(16'h0001);
        check("edge pulses", n_irq, 2);
        frame(24'h028042, 0, 0);
        frame(24'ha00000, 0, 0);
        check("irq cleared", 32'(irq_out), 32'h1);
        pulse(16'h0001);
        wait_irq(1'b0);
        pulse(16'h0002);
        check("irq latched", 32'(irq_out), 32'h0);
        frame(24'ha00000, 0, 0);
        check("irq released", 32'(irq_out), 32'h1);
        pulse(16'h0002);
        check("masked event", 32'(irq_out), 32'h1);
        frame(24'h200003, 0, 0);
        check("flags", rx, 32'ha00003);
        $display("interrupt test done");

        frame(24'h028052, 0, 0);
        frame(24'h224321, 1, 0);
        check("crc first", rx, 32'h02805200);
        frame(24'h229999, 1, 1);
        check("crc echo", rx, {24'h224321, crc8(24'h224321)});
        check("link_cfg", 32'(link_cfg), 32'h4321);
        frame(24'ha40000, 1, 1);
        check("bad write", rx, BAD_CRC_WORD);
        frame(24'ha20000, 1, 0);
        check("bad read", rx, BAD_CRC_WORD);
        check("rx pops", n_rd, 1);
        frame(24'h028042, 1, 0);
        check("crc read", rx, {24'ha24321, crc8(24'ha24321)});
        $display("checksum test done");

        frame(24'h021042, 0, 0);
        frame(24'h21fdff, 0, 0);
        frame(24'ha00000, 0, 0);
        repeat (70) @(negedge clk_in);
        check("wd early", 32'(irq_out), 32'h1);
        wait_irq(1'b0);
        $display("watchdog test done");

        frame(24'h070001, 0, 0);
        check("flushes", n_flush, 1);
        check("link_cfg", 32'(link_cfg), 32'h0);
        check("irq idle", 32'(irq_out), 32'h1);
        frame(24'h820000, 0, 0);
        check("reset echo", rx, 32'h070001);
        frame(24'h820000, 0, 0);
        check("host cfg", rx, 32'h828042);
        $display("soft reset test done");

        idle_hi = 1'b1;
        frame(24'h224567, 0, 0);
        check("idle high reply", rx, 32'h828042);
        frame(24'ha20000, 0, 0);
        check("idle high echo", rx, 32'h224567);
        check("link_cfg", 32'(link_cfg), 32'h4567);
        $display("idle high test done");

        @(negedge clk_in) srst_in = 1'b1;
        repeat (10) @(negedge clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check("link_cfg", 32'(link_cfg), 32'h0);
        frame(24'h820000, 0, 0);
        check("reset reply", rx, 32'h0);
        $display("reset test done");
        close_out();
    end
endmodule
